// File: src/lpsr_pkg.sv
/*
  constants shared by the latched parallel-in serial-out shift register block:
  register offsets, field positions, reset values and widths.
  assumes a single 100 MHz clock and an apb master on the register side.
*/
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package lpsr_pkg;

  // --------------------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------------------
  localparam int unsigned LPSR_WIDTH  = 8;   // stages in latch and shift register
  localparam int unsigned LPSR_ADDR_W = 12;  // apb address bits decoded

  // --------------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // --------------------------------------------------------------------------
  localparam logic [11:0] LPSR_OFS_CTRL   = 12'h000;  // control
  localparam logic [11:0] LPSR_OFS_STATUS = 12'h004;  // live state, read only
  localparam logic [11:0] LPSR_OFS_LATCH  = 12'h008;  // latch contents, read only

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int unsigned LPSR_CTRL_SEL_B   = 0;   // serial input select, 1 = input b
  localparam int unsigned LPSR_CTRL_CLR_B   = 1;   // write 1: one-cycle software clear
  localparam int unsigned LPSR_STAT_PEND_B  = 8;   // a shift edge waits on the buffer
  localparam int unsigned LPSR_STAT_SOUT_B  = 9;   // serial output level
  localparam int unsigned LPSR_STAT_BVAL_B  = 10;  // buffer holds a bit

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic       LPSR_RST_SEL  = 1'b0;     // serial input a after reset
  localparam logic [7:0] LPSR_RST_DATA = 8'h00;    // latch and stages after reset

endpackage

// File: src/lpsr_buf.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes a single clock and an active-low asynchronous reset; in_ready
  is a flop, so a full buffer stalls its source without a loop.
*/
`timescale 1ns/1ns
module lpsr_buf #(
  parameter int unsigned W = 1  // data width
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [W-1:0] mem [2];      // two entries
  logic         wr_ptr;       // next slot to fill
  logic         rd_ptr;       // oldest slot
  logic [1:0]   level;        // entries held
  logic         push;         // entry accepted this cycle
  logic         pop;          // entry drained this cycle
  logic [1:0]   next_level;   // level after this cycle

  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign next_level = level + {1'b0, push} - {1'b0, pop};
  assign out_data   = mem[rd_ptr];

  // --------------------------------------------------------------------------
  // pointers and flags; full and empty follow the real level
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr    <= 1'b0;
      rd_ptr    <= 1'b0;
      level     <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= wr_ptr ^ push;
      rd_ptr    <= rd_ptr ^ pop;
      level     <= next_level;
      in_ready  <= (next_level != 2'h2);
      out_valid <= (next_level != 2'h0);
    end
  end

  // data slots carry no reset, they are only read while valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// File: src/lpsr_top.sv
/*
  latched parallel-in serial-out shift register with tri-state parallel
  ports, selectable serial input, direct load and clear, and an apb slave.
  assumes every pin input is synchronous to clk; the two device clocks are
  sampled as levels and their rising edges found by comparison.
*/
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module lpsr_top
  import lpsr_pkg::*;
#(
  parameter int unsigned WIDTH = LPSR_WIDTH  // stages
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // device pins
  input  wire logic                   shift_clk,
  input  wire logic                   latch_clk,
  input  wire logic                   shift_load_n,
  input  wire logic                   shift_clear_n,
  input  wire logic                   shift_clk_en_n,
  input  wire logic                   serial_in_a,
  input  wire logic                   serial_in_b,
  input  wire logic                   out_en_n,
  input  wire logic [WIDTH-1:0]       par_in,
  output logic      [WIDTH-1:0]       par_out,
  output logic                        par_oe_n,
  output logic                        serial_out,
  // stream of bits shifted into the last stage
  output logic                        bit_valid,
  input  wire logic                   bit_ready,
  output logic                        bit_data,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [LPSR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] latch_q;      // storage latch
  logic [WIDTH-1:0] sreg;         // shift register stages
  logic [WIDTH-1:0] next_sreg;    // stage values after this cycle
  logic             sclk_d;       // shift clock one cycle ago
  logic             lclk_d;       // latch clock one cycle ago
  logic             sclk_rise;    // shift clock rising edge seen
  logic             lclk_rise;    // latch clock rising edge seen
  logic             shift_req;    // enabled shift edge
  logic             pend;         // enabled edge waiting for buffer room
  logic             next_pend;    // pend after this cycle
  logic             do_shift;     // shift happens this cycle
  logic             ser_sel;      // serial input select from ctrl
  logic             sw_clr;       // one-cycle software clear
  logic             clr_any;      // pin clear or software clear
  logic             ser_bit;      // selected serial input
  logic             buf_ready;    // buffer has room
  logic             apb_acc;      // access phase waiting for answer
  logic             hit_ctrl;     // address decodes to ctrl
  logic             hit_status;   // address decodes to status
  logic             hit_latch;    // address decodes to latch
  logic             hit_any;      // address is mapped
  logic [31:0]      rd_mux;       // read data selected by address
  logic [31:0]      status_word;  // live status view

  // --------------------------------------------------------------------------
  // address decode, shared by read and write paths
  // --------------------------------------------------------------------------
  function automatic logic addr_is(input logic [LPSR_ADDR_W-1:0] a,
                                   input logic [11:0]            ofs);
    addr_is = (a == ofs);
  endfunction

  assign apb_acc    = psel & penable & ~pready;
  assign hit_ctrl   = addr_is(paddr, LPSR_OFS_CTRL);
  assign hit_status = addr_is(paddr, LPSR_OFS_STATUS);
  assign hit_latch  = addr_is(paddr, LPSR_OFS_LATCH);
  assign hit_any    = hit_ctrl | hit_status | hit_latch;

  // --------------------------------------------------------------------------
  // edge detection on the sampled device clocks
  // --------------------------------------------------------------------------
  assign sclk_rise = shift_clk & ~sclk_d;
  assign lclk_rise = latch_clk & ~lclk_d;
  assign shift_req = sclk_rise & ~shift_clk_en_n;
  assign clr_any   = ~shift_clear_n | sw_clr;
  assign ser_bit   = ser_sel ? serial_in_b : serial_in_a;

  // a shift waits while the buffer is full; load and clear cancel it
  assign do_shift  = (shift_req | pend) & buf_ready & ~clr_any & shift_load_n;

  // previous clock levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d <= 1'b0;
      lclk_d <= 1'b0;
    end else begin
      sclk_d <= shift_clk;
      lclk_d <= latch_clk;
    end
  end

  // --------------------------------------------------------------------------
  // storage latch
  // --------------------------------------------------------------------------
  // par_in is the resolved port level: while the device drives the ports it
  // reads back its own stages, otherwise the host's data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_q <= LPSR_RST_DATA;
    end else if (lclk_rise) begin
      latch_q <= par_in;
    end
  end

  // --------------------------------------------------------------------------
  // shift register stages, priority clear, load, shift, hold
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_stage
      if (gi == 0) begin : g_first
        assign next_sreg[gi] = clr_any ? 1'b0 :
                               !shift_load_n ? latch_q[gi] :
                               do_shift ? ser_bit : sreg[gi];
      end else begin : g_rest
        assign next_sreg[gi] = clr_any ? 1'b0 :
                               !shift_load_n ? latch_q[gi] :
                               do_shift ? sreg[gi-1] : sreg[gi];
      end
    end
  endgenerate

  // a level held low on load or clear acts every cycle, like the direct inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sreg <= LPSR_RST_DATA;
    end else begin
      sreg <= next_sreg;
    end
  end

  // a second enabled edge during a stall is lost; status shows the stall
  always_comb begin
    next_pend = pend;
    if (clr_any || !shift_load_n) begin
      next_pend = 1'b0;
    end else if (do_shift) begin
      next_pend = 1'b0;
    end else if (shift_req) begin
      next_pend = 1'b1;
    end
  end

  // pending shift flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
    end else begin
      pend <= next_pend;
    end
  end

  // --------------------------------------------------------------------------
  // pins driven straight from flops
  // --------------------------------------------------------------------------
  assign par_out    = sreg;
  assign serial_out = sreg[WIDTH-1];

  // output enable follows the pin one cycle later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      par_oe_n <= 1'b1;
    end else begin
      par_oe_n <= out_en_n;
    end
  end

  // --------------------------------------------------------------------------
  // bit buffer: every bit shifted into the last stage goes to the consumer
  // --------------------------------------------------------------------------
  lpsr_buf #(
    .W (1)
  ) u_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (do_shift),
    .in_ready  (buf_ready),
    .in_data   (sreg[WIDTH-2]),
    .out_valid (bit_valid),
    .out_ready (bit_ready),
    .out_data  (bit_data)
  );

  // --------------------------------------------------------------------------
  // apb slave, one wait state, answer registered
  // --------------------------------------------------------------------------
  assign status_word = {21'h0, bit_valid, serial_out, pend, 8'(sreg)};

  assign rd_mux = hit_ctrl   ? {31'h0, ser_sel} :
                  hit_status ? status_word :
                  hit_latch  ? {24'h0, latch_q} : 32'h0;

  // answer on the second access cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~hit_any;
      prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // control register, write takes effect at the completing edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_sel <= LPSR_RST_SEL;
      sw_clr  <= 1'b0;
    end else begin
      sw_clr <= 1'b0;
      if (psel && penable && pready && pwrite && hit_ctrl) begin
        ser_sel <= pwdata[LPSR_CTRL_SEL_B];
        sw_clr  <= pwdata[LPSR_CTRL_CLR_B];
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence seq_latch_edge;
    lclk_rise && shift_clear_n && !sw_clr;
  endsequence

  sequence seq_load_after;
    !shift_load_n && shift_clear_n && !sw_clr && !lclk_rise;
  endsequence

  AST_CLEAR: assert property (!shift_clear_n |=> sreg == '0 && !serial_out)
    else $error("stages not cleared");

  AST_LOAD: assert property (
    (!shift_load_n && shift_clear_n && !sw_clr) |=> sreg == $past(latch_q))
    else $error("load did not copy latch");

  AST_LATCH: assert property (lclk_rise |=> latch_q == $past(par_in))
    else $error("latch missed port data");

  AST_LATCH_HOLD: assert property (!lclk_rise |=> $stable(latch_q))
    else $error("latch changed without edge");

  AST_FRESH_LOAD: assert property (
    seq_latch_edge ##1 seq_load_after |=> sreg == $past(par_in, 2))
    else $error("fresh latch data not loaded");

  AST_SHIFT: assert property (
    do_shift |=> sreg == {$past(sreg[WIDTH-2:0]), $past(ser_bit)})
    else $error("shift moved stages wrongly");

  AST_NO_EN: assert property (
    (shift_clk_en_n && !pend && shift_clear_n && !sw_clr && shift_load_n)
    |=> $stable(sreg))
    else $error("stages moved while disabled");

  AST_OE: assert property (out_en_n |=> par_oe_n)
    else $error("ports driven while disabled");

  AST_APB_WAIT: assert property (apb_acc |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  // a shift edge that meets a full buffer is remembered, not dropped
  sequence seq_stalled;
    shift_req && !buf_ready && shift_clear_n && !sw_clr && shift_load_n;
  endsequence

  AST_PEND_SET: assert property (seq_stalled |=> pend)
    else $error("stalled shift not held");

  AST_PEND_GO: assert property (
    seq_stalled ##1 (pend && buf_ready && shift_clear_n && !sw_clr && shift_load_n)
    |=> !pend)
    else $error("held shift never went out");

  AST_OE_ON: assert property (!out_en_n |=> !par_oe_n)
    else $error("ports not driven while enabled");

  AST_SW_CLR: assert property (sw_clr |=> sreg == '0)
    else $error("software clear left stages set");

  AST_CTRL_WR: assert property (
    (psel && penable && pready && pwrite && hit_ctrl)
    |=> ser_sel == $past(pwdata[LPSR_CTRL_SEL_B]))
    else $error("serial select write lost");

  AST_APB_ERR: assert property ((apb_acc && !hit_any) |=> pready && pslverr)
    else $error("unmapped access not flagged");

  AST_RD_LATCH: assert property (
    (apb_acc && !pwrite && hit_latch) |=> prdata[WIDTH-1:0] == $past(latch_q))
    else $error("latch read returned wrong data");

endmodule

// File: tb/lpsr_host.sv
/*
  host model: drives the device clocks and controls, consumes the bit stream.
  assumes its tasks are entered just after a rising edge of clk.
*/
`timescale 1ns/1ns
module lpsr_host (
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic bit_valid,
  output logic      bit_ready,
  output logic      shift_clk,
  output logic      latch_clk,
  output logic      shift_load_n,
  output logic      shift_clear_n,
  output logic      shift_clk_en_n
);
  // ---------------------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------------------
  initial begin
    bit_ready = 1'b0;
    {shift_clk, latch_clk} = 2'b00;
    {shift_load_n, shift_clear_n, shift_clk_en_n} = 3'b111;
  end
  // consumer takes bits at random, so the buffer sees stalls
  always @(posedge clk) begin
    bit_ready <= !stall && (!bit_valid || ($urandom_range(1) == 0));
  end
  // one cycle high then one low: the device needs a low sample between edges
  task automatic pulse_shift(input logic en);
    shift_clk_en_n <= !en;  // enable low in the cycle of the edge
    shift_clk      <= 1'b1;
    @(posedge clk);
    shift_clk      <= 1'b0;
    shift_clk_en_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic pulse_latch();
    latch_clk <= 1'b1;
    @(posedge clk);
    latch_clk <= 1'b0;
    @(posedge clk);
  endtask
  // load released only after the latch edge, so new data reaches the stages
  task automatic load(input logic with_latch);
    shift_load_n <= 1'b0;
    @(posedge clk);
    if (with_latch) begin
      pulse_latch();
    end
    @(posedge clk);
    shift_load_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic clear();
    shift_clear_n <= 1'b0;
    repeat (2) @(posedge clk);
    shift_clear_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// File: tb/latched_piso_shift_register_tb.sv
/*
  self-checking bench for lpsr_top: apb tasks, a reference of latch, stages
  and bit stream, random data from a fixed seed.
  assumes lpsr_host drives the device clocks and takes the bits.
*/
`timescale 1ns/1ns
module latched_piso_shift_register_tb;
  import lpsr_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        stall = 1'b0;      // consumer holds off
  logic        serial_in_a = 1'b0;
  logic        serial_in_b = 1'b0;
  logic        out_en_n = 1'b1;
  logic [7:0]  host_par = 8'h00;  // host level on the port
  wire  [7:0]  par_in;
  logic [7:0]  par_out;
  logic        par_oe_n, serial_out, bit_valid, bit_ready, bit_data;
  logic        shift_clk, latch_clk, shift_load_n, shift_clear_n, shift_clk_en_n;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, sel;
  logic [7:0]  exp_latch = 8'h00, exp_sreg = 8'h00;  // reference state
  logic        exp_q[$];          // bits still to leave the buffer
  int          err_total = 0, cmp_count = 0, r, i;
  // a released port shows the host level, a driven one the stages
  assign par_in = (par_oe_n === 1'b0) ? par_out : host_par;
  always #5 clk = ~clk;
  lpsr_top u_dut (.clk(clk), .nrst(nrst), .shift_clk(shift_clk), .latch_clk(latch_clk),
    .shift_load_n(shift_load_n), .shift_clear_n(shift_clear_n),
    .shift_clk_en_n(shift_clk_en_n), .serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
    .out_en_n(out_en_n), .par_in(par_in), .par_out(par_out), .par_oe_n(par_oe_n),
    .serial_out(serial_out), .bit_valid(bit_valid), .bit_ready(bit_ready),
    .bit_data(bit_data), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lpsr_host u_host (.clk(clk), .stall(stall), .bit_valid(bit_valid), .bit_ready(bit_ready),
    .shift_clk(shift_clk), .latch_clk(latch_clk), .shift_load_n(shift_load_n),
    .shift_clear_n(shift_clear_n), .shift_clk_en_n(shift_clk_en_n));
  // ---------------------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask
  // waits for the answer however long it takes; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic drain();
    while (bit_valid !== 1'b0) @(posedge clk);
  endtask
  // stuck: the buffer is full, so the edge waits and the output keeps its bit
  task automatic shift_one(input logic wait_drain, input logic stuck);
    logic a, b, old;
    a = 1'($urandom_range(1));
    b = 1'($urandom_range(1));
    serial_in_a <= a;
    serial_in_b <= b;
    old = exp_sreg[7];
    exp_sreg = {exp_sreg[6:0], sel ? b : a};
    exp_q.push_back(exp_sreg[7]);
    u_host.pulse_shift(1'b1);
    check_bit(serial_out, stuck ? old : exp_sreg[7]);
    @(posedge clk);
    if (wait_drain) drain();
  endtask
  task automatic check_stages();
    apb(1'b0, LPSR_OFS_STATUS, 32'h0);
    check_word({24'h0, rd[7:0]}, {24'h0, exp_sreg});
  endtask
  // every bit leaving the buffer must match the shift order
  always @(posedge clk) begin
    if (bit_valid === 1'b1 && bit_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_word(32'h1, 32'h0);
      end else begin
        check_bit(bit_data, exp_q.pop_front());
      end
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(61));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check_bit(par_oe_n, 1'b1);
    apb(1'b0, LPSR_OFS_CTRL, 32'h0);
    check_word(rd, 32'h0);
    check_stages();
    apb(1'b0, LPSR_OFS_LATCH, 32'h0);
    check_word(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check_bit(er, 1'b1);
    for (r = 0; r < 4; r++) begin
      sel = r[0];
      apb(1'b1, LPSR_OFS_CTRL, {31'h0, sel});
      apb(1'b0, LPSR_OFS_CTRL, 32'h0);
      check_word(rd, {31'h0, sel});
      exp_latch = 8'($urandom);
      host_par <= exp_latch;
      @(posedge clk);
      u_host.pulse_latch();
      apb(1'b0, LPSR_OFS_LATCH, 32'h0);
      check_word(rd, {24'h0, exp_latch});
      u_host.load(1'b0);
      exp_sreg = exp_latch;
      check_stages();
      u_host.pulse_shift(1'b0);
      check_stages();
      for (i = 0; i < 8; i++) shift_one(1'b1, 1'b0);
      out_en_n <= 1'b0;
      repeat (3) @(posedge clk);
      check_bit(par_oe_n, 1'b0);
      check_word({24'h0, par_out}, {24'h0, exp_sreg});
      u_host.pulse_latch();
      exp_latch = exp_sreg;
      apb(1'b0, LPSR_OFS_LATCH, 32'h0);
      check_word(rd, {24'h0, exp_latch});
      out_en_n <= 1'b1;
      repeat (3) @(posedge clk);
      check_bit(par_oe_n, 1'b1);
    end
    exp_latch = 8'($urandom);
    host_par <= exp_latch;
    u_host.load(1'b1);
    exp_sreg = exp_latch;
    check_stages();
    stall <= 1'b1;
    repeat (2) @(posedge clk);
    repeat (2) shift_one(1'b0, 1'b0);
    shift_one(1'b0, 1'b1);
    apb(1'b0, LPSR_OFS_STATUS, 32'h0);
    check_bit(rd[LPSR_STAT_PEND_B], 1'b1);
    check_bit(rd[LPSR_STAT_BVAL_B], 1'b1);
    check_bit(rd[LPSR_STAT_SOUT_B], exp_q[1]);
    check_bit(bit_valid, 1'b1);
    stall <= 1'b0;
    repeat (2) @(posedge clk);
    drain();
    repeat (2) @(posedge clk);
    check_stages();
    check_word(exp_q.size(), 32'h0);
    u_host.clear();
    exp_sreg = 8'h00;
    check_bit(serial_out, 1'b0);
    check_stages();
    give_verdict();
  end
  initial begin
    #300000;
    err_total++;
    give_verdict();
  end
endmodule
